// [include/mcsr_pkg.sv]
// Constants of the meter control and status register group.
// Assumes a host register port on the device clock and event pulses from the same clock domain.
package mcsr_pkg;

   // ********************************************************
   // Register addressing
   // ********************************************************
   localparam int unsigned PAGE_W = 8;
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 24;
   localparam logic [7:0] PAGE_MAIN = 8'h00;
   localparam logic [7:0] PAGE_CAL = 8'h10;
   localparam logic [5:0] OFF_INTERRUPT_ENABLE_MASK = 6'h03;
   localparam logic [5:0] OFF_PULSE_SOURCE_CONTROL = 6'h09;
   localparam logic [5:0] OFF_EVENT_STATUS = 6'h17;
   localparam logic [5:0] OFF_CONDITION_STATUS = 6'h18;
   localparam logic [5:0] OFF_WRITE_LOCK_CONTROL = 6'h22;
   localparam logic [5:0] OFF_PHASE_SEQUENCE_CONTROL = 6'h30;
   localparam logic [5:0] OFF_CRITICAL_CHECKSUM = 6'h01;

   // ********************************************************
   // Reset values and writable bits
   // ********************************************************
   localparam logic [23:0] RST_INTERRUPT_ENABLE_MASK = 24'h000000;
   localparam logic [23:0] RST_PULSE_SOURCE_CONTROL = 24'h000000;
   localparam logic [23:0] RST_EVENT_STATUS = 24'h800000;
   localparam logic [23:0] RST_CONDITION_STATUS = 24'h801800;
   localparam logic [23:0] CSTAT_FIXED_MASK = 24'h800000;
   localparam logic [23:0] RST_CRITICAL_CHECKSUM = 24'h000000;
   localparam logic [4:0] RST_LOCK_FIELD = 5'h00;
   localparam logic [23:0] EVENT_BITS_MASK = 24'he7fffd;
   localparam logic [23:0] PULSE_BITS_MASK = 24'h000fff;

   // ********************************************************
   // Field positions and codes
   // ********************************************************
   localparam int unsigned SEL_W = 4;
   localparam int unsigned SEL1_LSB = 0;
   localparam int unsigned SEL2_LSB = 4;
   localparam int unsigned SEL3_LSB = 8;
   localparam int unsigned ENGINE_LOCK_LSB = 8;
   localparam int unsigned HOST_LOCK_LSB = 0;
   localparam logic [4:0] LOCK_CODE = 5'h16;
   localparam logic [4:0] UNLOCK_CODE = 5'h09;
   localparam int unsigned PS_CODE_LSB = 0;
   localparam int unsigned PS_DIR_BIT = 5;
   localparam int unsigned PS_COUNT_LSB = 16;
   localparam int unsigned PS_DONE_BIT = 23;
   localparam logic [4:0] PS_START_CODE = 5'b10110;
   localparam int unsigned LAST_CMD_LSB = 8;

   // Event status bit positions.
   localparam int unsigned EV_LOW_RATE = 23;
   localparam int unsigned EV_SAMPLE_RATE = 22;
   localparam int unsigned EV_WATCHDOG = 21;
   localparam int unsigned EV_OVERRUN = 18;
   localparam int unsigned EV_SWELL1 = 16;
   localparam int unsigned EV_POWER_RANGE1 = 14;
   localparam int unsigned EV_CURRENT_RANGE1 = 12;
   localparam int unsigned EV_VOLTAGE_RANGE1 = 10;
   localparam int unsigned EV_OVERCURRENT1 = 8;
   localparam int unsigned EV_SAG1 = 6;
   localparam int unsigned EV_TEMPERATURE = 5;
   localparam int unsigned EV_FREQUENCY = 4;
   localparam int unsigned EV_BAD_COMMAND = 3;
   localparam int unsigned EV_RX_CHECKSUM = 2;
   localparam int unsigned EV_RX_TIMEOUT = 0;

   // Phase sequence detector states, Gray coded along idle, count, done.
   typedef enum logic [1:0] {
      MCSR_PS_IDLE = 2'b00,
      MCSR_PS_COUNT = 2'b01,
      MCSR_PS_DONE = 2'b11,
      MCSR_PS_FAIL = 2'b10
   } mcsr_ps_t;

endpackage

// [design/mcsr_regs.sv]
// Control and status register group of a three-channel energy measurement front end.
// Assumes the serial framing outside decodes commands into single-cycle register accesses
// and that every event input is a one-cycle pulse on mclk.
`timescale 1ns/100ps

module mcsr_regs (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic host_wr_en,
   input wire logic host_rd_en,
   input wire logic [7:0] host_page,
   input wire logic [5:0] host_addr,
   input wire logic [23:0] host_wr_data,
   output logic [23:0] host_rd_data,
   output logic host_rd_valid,
   output logic host_wr_refused,
   input wire logic cmd_done,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic cmd_invalid,
   input wire logic low_rate_update,
   input wire logic sample_rate_update,
   input wire logic watchdog_overflow,
   input wire logic processing_overrun,
   input wire logic [1:0] voltage_swell,
   input wire logic [1:0] voltage_sag,
   input wire logic [1:0] current_overcurrent,
   input wire logic [1:0] power_range,
   input wire logic [1:0] current_range,
   input wire logic [1:0] voltage_range,
   input wire logic temperature_update,
   input wire logic frequency_update,
   input wire logic receive_checksum_error,
   input wire logic receive_timeout,
   input wire logic temp_modulator_osc,
   input wire logic voltage_modulator_osc,
   input wire logic current2_modulator_osc,
   input wire logic current1_modulator_osc,
   input wire logic output_word_rate_tick,
   input wire logic zero_cross_rise,
   input wire logic zero_cross_fall,
   output logic [3:0] pulse_source_select1,
   output logic [3:0] pulse_source_select2,
   output logic [3:0] pulse_source_select3,
   output logic engine_lock,
   output logic host_lock,
   output logic interrupt_n
);

   // ********************************************************
   // State
   // ********************************************************
   typedef struct packed {
      logic [23:0] mask;
      logic [23:0] pulse;
      logic [23:0] status;
      logic [7:0] last_cmd;
      logic [3:0] osc;
      logic [4:0] engine_lock_field;
      logic [4:0] host_lock_field;
      logic [4:0] ps_code;
      logic ps_dir;
      mcsr_pkg::mcsr_ps_t ps_state;
      logic [6:0] ps_count;
      logic [23:0] checksum;
      logic [23:0] rd_data;
      logic rd_valid;
      logic irq;
   } mcsr_state_t;

   mcsr_state_t s_q;
   mcsr_state_t s_d;

   logic wr_main;
   logic sel_lock;
   logic sel_status;
   logic sel_cstat;
   logic host_locked;
   logic wr_ok;
   logic [23:0] events;
   logic [23:0] clear_bits;
   logic [23:0] phase_sequence_control_read;
   logic [23:0] lock_read;
   logic [23:0] cstat_read;
   logic stop_edge;

   // ********************************************************
   // Address decode and write permission
   // ********************************************************
   assign wr_main = host_page == mcsr_pkg::PAGE_MAIN;
   assign sel_lock = wr_main && host_addr == mcsr_pkg::OFF_WRITE_LOCK_CONTROL;
   assign sel_status = wr_main && host_addr == mcsr_pkg::OFF_EVENT_STATUS;
   assign sel_cstat = wr_main && host_addr == mcsr_pkg::OFF_CONDITION_STATUS;
   assign host_locked = s_q.host_lock_field == mcsr_pkg::LOCK_CODE;
   assign wr_ok = host_wr_en && (!host_locked || sel_lock || sel_status || sel_cstat);
   assign host_wr_refused = host_wr_en && !wr_ok;

   // ********************************************************
   // Event collection
   // ********************************************************
   always_comb begin
      events = '0;
      events[mcsr_pkg::EV_LOW_RATE] = low_rate_update || cmd_done;
      events[mcsr_pkg::EV_SAMPLE_RATE] = sample_rate_update;
      events[mcsr_pkg::EV_WATCHDOG] = watchdog_overflow;
      events[mcsr_pkg::EV_OVERRUN] = processing_overrun;
      events[mcsr_pkg::EV_SWELL1 +: 2] = voltage_swell;
      events[mcsr_pkg::EV_SAG1 +: 2] = voltage_sag;
      events[mcsr_pkg::EV_OVERCURRENT1 +: 2] = current_overcurrent;
      events[mcsr_pkg::EV_POWER_RANGE1 +: 2] = power_range;
      events[mcsr_pkg::EV_CURRENT_RANGE1 +: 2] = current_range;
      events[mcsr_pkg::EV_VOLTAGE_RANGE1 +: 2] = voltage_range;
      events[mcsr_pkg::EV_TEMPERATURE] = temperature_update;
      events[mcsr_pkg::EV_FREQUENCY] = frequency_update;
      events[mcsr_pkg::EV_BAD_COMMAND] = cmd_invalid;
      events[mcsr_pkg::EV_RX_CHECKSUM] = receive_checksum_error;
      events[mcsr_pkg::EV_RX_TIMEOUT] = receive_timeout;
   end

   assign clear_bits = (wr_ok && sel_status) ? host_wr_data : 24'h000000;
   assign stop_edge = s_q.ps_dir ? zero_cross_fall : zero_cross_rise;

   // ********************************************************
   // Read views
   // ********************************************************
   // reserved bits read zero; condition status bit 23 reads a fixed one
   always_comb begin
      lock_read = '0;
      lock_read[mcsr_pkg::ENGINE_LOCK_LSB +: 5] = s_q.engine_lock_field;
      lock_read[mcsr_pkg::HOST_LOCK_LSB +: 5] = s_q.host_lock_field;
      phase_sequence_control_read = '0;
      phase_sequence_control_read[mcsr_pkg::PS_CODE_LSB +: 5] = s_q.ps_code;
      phase_sequence_control_read[mcsr_pkg::PS_DIR_BIT] = s_q.ps_dir;
      phase_sequence_control_read[mcsr_pkg::PS_COUNT_LSB +: 7] = s_q.ps_count;
      phase_sequence_control_read[mcsr_pkg::PS_DONE_BIT] = s_q.ps_state == mcsr_pkg::MCSR_PS_DONE;
      cstat_read = mcsr_pkg::RST_CONDITION_STATUS & mcsr_pkg::CSTAT_FIXED_MASK;
      cstat_read[mcsr_pkg::LAST_CMD_LSB +: 8] = s_q.last_cmd;
      cstat_read[3:0] = s_q.osc;
   end

   // ********************************************************
   // Next state
   // ********************************************************
   always_comb begin
      s_d = s_q;
      s_d.rd_valid = host_rd_en;

      if (wr_ok && wr_main && host_addr == mcsr_pkg::OFF_INTERRUPT_ENABLE_MASK) begin
         s_d.mask = host_wr_data & mcsr_pkg::EVENT_BITS_MASK;
      end
      if (wr_ok && wr_main && host_addr == mcsr_pkg::OFF_PULSE_SOURCE_CONTROL) begin
         s_d.pulse = host_wr_data & mcsr_pkg::PULSE_BITS_MASK;
      end

      if (wr_ok && sel_lock) begin
         if (host_wr_data[mcsr_pkg::ENGINE_LOCK_LSB +: 5] == mcsr_pkg::LOCK_CODE ||
             host_wr_data[mcsr_pkg::ENGINE_LOCK_LSB +: 5] == mcsr_pkg::UNLOCK_CODE) begin
            s_d.engine_lock_field = host_wr_data[mcsr_pkg::ENGINE_LOCK_LSB +: 5];
         end
         if (host_wr_data[mcsr_pkg::HOST_LOCK_LSB +: 5] == mcsr_pkg::LOCK_CODE ||
             host_wr_data[mcsr_pkg::HOST_LOCK_LSB +: 5] == mcsr_pkg::UNLOCK_CODE) begin
            s_d.host_lock_field = host_wr_data[mcsr_pkg::HOST_LOCK_LSB +: 5];
         end
      end

      s_d.status = ((s_q.status & ~clear_bits) | events) & mcsr_pkg::EVENT_BITS_MASK;

      if (cmd_valid) begin
         s_d.last_cmd = cmd_code;
      end
      s_d.osc = {temp_modulator_osc, voltage_modulator_osc,
                 current2_modulator_osc, current1_modulator_osc};

      unique case (s_q.ps_state)
         mcsr_pkg::MCSR_PS_COUNT: begin
            if (stop_edge) begin
               s_d.ps_state = mcsr_pkg::MCSR_PS_DONE;
            end else if (output_word_rate_tick) begin
               if (&s_q.ps_count) begin
                  s_d.ps_state = mcsr_pkg::MCSR_PS_FAIL;
               end else begin
                  s_d.ps_count = s_q.ps_count + 7'h01;
               end
            end
         end
         mcsr_pkg::MCSR_PS_IDLE,
         mcsr_pkg::MCSR_PS_DONE,
         mcsr_pkg::MCSR_PS_FAIL: begin
         end
      endcase

      if (wr_ok && wr_main && host_addr == mcsr_pkg::OFF_PHASE_SEQUENCE_CONTROL) begin
         s_d.ps_code = host_wr_data[mcsr_pkg::PS_CODE_LSB +: 5];
         s_d.ps_dir = host_wr_data[mcsr_pkg::PS_DIR_BIT];
         if (host_wr_data[mcsr_pkg::PS_CODE_LSB +: 5] == mcsr_pkg::PS_START_CODE) begin
            s_d.ps_state = mcsr_pkg::MCSR_PS_COUNT;
            s_d.ps_count = 7'h00;
         end
      end

      s_d.checksum = s_d.mask + s_d.pulse +
                     {11'h000, s_d.engine_lock_field, 3'h0, s_d.host_lock_field} +
                     {18'h00000, s_d.ps_dir, s_d.ps_code};

      s_d.irq = |(s_d.status & s_d.mask);

      // Reads return the register as it stands before this cycle's write.
      s_d.rd_data = 24'h000000;
      if (host_rd_en) begin
         if (host_page == mcsr_pkg::PAGE_CAL) begin
            if (host_addr == mcsr_pkg::OFF_CRITICAL_CHECKSUM) begin
               s_d.rd_data = s_q.checksum;
            end
         end else if (wr_main) begin
            unique case (host_addr)
               mcsr_pkg::OFF_INTERRUPT_ENABLE_MASK: s_d.rd_data = s_q.mask;
               mcsr_pkg::OFF_PULSE_SOURCE_CONTROL: s_d.rd_data = s_q.pulse;
               mcsr_pkg::OFF_EVENT_STATUS: s_d.rd_data = s_q.status;
               mcsr_pkg::OFF_CONDITION_STATUS: s_d.rd_data = cstat_read;
               mcsr_pkg::OFF_WRITE_LOCK_CONTROL: s_d.rd_data = lock_read;
               mcsr_pkg::OFF_PHASE_SEQUENCE_CONTROL: s_d.rd_data = phase_sequence_control_read;
               default: s_d.rd_data = 24'h000000;
            endcase
         end
      end
   end

   // ********************************************************
   // Registers
   // ********************************************************
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         s_q.mask <= mcsr_pkg::RST_INTERRUPT_ENABLE_MASK;
         s_q.pulse <= mcsr_pkg::RST_PULSE_SOURCE_CONTROL;
         s_q.status <= mcsr_pkg::RST_EVENT_STATUS;
         s_q.last_cmd <= mcsr_pkg::RST_CONDITION_STATUS[15:8];
         s_q.osc <= mcsr_pkg::RST_CONDITION_STATUS[3:0];
         s_q.engine_lock_field <= mcsr_pkg::RST_LOCK_FIELD;
         s_q.host_lock_field <= mcsr_pkg::RST_LOCK_FIELD;
         s_q.ps_code <= 5'h00;
         s_q.ps_dir <= 1'b0;
         s_q.ps_state <= mcsr_pkg::MCSR_PS_IDLE;
         s_q.ps_count <= 7'h00;
         s_q.checksum <= mcsr_pkg::RST_CRITICAL_CHECKSUM;
         s_q.rd_data <= 24'h000000;
         s_q.rd_valid <= 1'b0;
         s_q.irq <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ********************************************************
   // Outputs
   // ********************************************************
   // selected sources drive the generators
   assign pulse_source_select1 = s_q.pulse[mcsr_pkg::SEL1_LSB +: mcsr_pkg::SEL_W];
   assign pulse_source_select2 = s_q.pulse[mcsr_pkg::SEL2_LSB +: mcsr_pkg::SEL_W];
   assign pulse_source_select3 = s_q.pulse[mcsr_pkg::SEL3_LSB +: mcsr_pkg::SEL_W];
   assign engine_lock = s_q.engine_lock_field == mcsr_pkg::LOCK_CODE;
   assign host_lock = host_locked;
   assign host_rd_data = s_q.rd_data;
   assign host_rd_valid = s_q.rd_valid;
   assign interrupt_n = !s_q.irq;

endmodule

// [tb/mcsr_regs_assertions.sv]
// Port checker of the meter control and status register group.
// Assumes it is bound to mcsr_regs, one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module mcsr_regs_assertions (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic host_wr_en,
   input wire logic host_rd_en,
   input wire logic [7:0] host_page,
   input wire logic [5:0] host_addr,
   input wire logic [23:0] host_wr_data,
   input wire logic [23:0] host_rd_data,
   input wire logic host_rd_valid,
   input wire logic host_wr_refused,
   input wire logic [3:0] pulse_source_select1,
   input wire logic [3:0] pulse_source_select2,
   input wire logic [3:0] pulse_source_select3,
   input wire logic engine_lock,
   input wire logic host_lock,
   input wire logic interrupt_n
);
   // ********************************************************
   // Decodes
   // ********************************************************
   wire logic main_pg = host_page == mcsr_pkg::PAGE_MAIN;
   wire logic lk_wr = host_wr_en && main_pg && host_addr == mcsr_pkg::OFF_WRITE_LOCK_CONTROL;
   wire logic ps_wr = host_wr_en && !host_wr_refused && main_pg &&
      host_addr == mcsr_pkg::OFF_PULSE_SOURCE_CONTROL;
   wire logic ex = main_pg && (host_addr == 6'h22 || host_addr == 6'h17 || host_addr == 6'h18);
   wire logic [4:0] ef = host_wr_data[12:8];
   wire logic [4:0] hf = host_wr_data[4:0];
   wire logic ef_ok = ef == mcsr_pkg::LOCK_CODE || ef == mcsr_pkg::UNLOCK_CODE;
   wire logic hf_ok = hf == mcsr_pkg::LOCK_CODE || hf == mcsr_pkg::UNLOCK_CODE;
   wire logic [11:0] sels = {pulse_source_select3, pulse_source_select2, pulse_source_select1};

   // ********************************************************
   // Properties
   // ********************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   a_select_update: assert property (ps_wr |=> sels == $past(host_wr_data[11:0]))
      else $error("pulse selectors missed an accepted write");
   a_select_hold: assert property (!ps_wr |=> $stable(sels))
      else $error("pulse selectors changed without a write");
   a_engine_set: assert property (lk_wr && ef == mcsr_pkg::LOCK_CODE |=> engine_lock)
      else $error("engine lock not set by lock code");
   a_engine_clear: assert property (lk_wr && ef == mcsr_pkg::UNLOCK_CODE |=> !engine_lock)
      else $error("engine lock not cleared by unlock code");
   a_engine_lock_hold: assert property (!(lk_wr && ef_ok) |=> $stable(engine_lock))
      else $error("engine lock changed without a lock code");
   a_host_switch: assert property (lk_wr && hf_ok |=>
      host_lock == ($past(hf) == mcsr_pkg::LOCK_CODE))
      else $error("host lock did not follow lock code");
   a_host_lock_hold: assert property (!(lk_wr && hf_ok) |=> $stable(host_lock))
      else $error("host lock changed without a lock code");
   a_lock_refuse: assert property (host_wr_en && host_lock && !ex |-> host_wr_refused)
      else $error("locked write was not refused");
   a_lock_exempt: assert property (!host_wr_en || !host_lock || ex |-> !host_wr_refused)
      else $error("write refused without host lock");
   a_reset_values: assert property ($rose(reset_n) |-> interrupt_n && !engine_lock &&
      !host_lock && sels == 12'h000)
      else $error("outputs not at reset values");
   a_read_answer: assert property (1'b1 |=> host_rd_valid == $past(host_rd_en) &&
      (host_rd_valid || host_rd_data == 24'h000000))
      else $error("read answer timing wrong");

   c_refused: cover property (host_wr_refused);
   c_interrupt: cover property ($fell(interrupt_n));
   c_engine_lock: cover property ($rose(engine_lock));
endmodule

bind mcsr_regs mcsr_regs_assertions u_mcsr_regs_assertions (.mclk(mclk), .reset_n(reset_n),
   .host_wr_en(host_wr_en), .host_rd_en(host_rd_en), .host_page(host_page),
   .host_addr(host_addr), .host_wr_data(host_wr_data), .host_rd_data(host_rd_data),
   .host_rd_valid(host_rd_valid), .host_wr_refused(host_wr_refused),
   .pulse_source_select1(pulse_source_select1), .pulse_source_select2(pulse_source_select2),
   .pulse_source_select3(pulse_source_select3), .engine_lock(engine_lock),
   .host_lock(host_lock), .interrupt_n(interrupt_n));

// [tb/mcsr_host_model.sv]
// Host side of the register port: single-word writes and reads.
// Assumes one access at a time, driven 1 ns after the rising edge of mclk.
`timescale 1ns/100ps
module mcsr_host_model (
   input wire logic mclk,
   output logic host_wr_en,
   output logic host_rd_en,
   output logic [7:0] host_page,
   output logic [5:0] host_addr,
   output logic [23:0] host_wr_data,
   input wire logic [23:0] host_rd_data,
   input wire logic host_rd_valid,
   input wire logic host_wr_refused
);
   initial begin
      host_wr_en = 1'b0;
      host_rd_en = 1'b0;
      host_page = 8'h00;
      host_addr = 6'h00;
      host_wr_data = 24'h000000;
   end

   // Released address and data lines are inverted, the page is kept, so that stale values are never read as valid.
   task automatic wr(input logic [7:0] pg, input logic [5:0] ad, input logic [23:0] dt,
      output logic rf);
      @(posedge mclk);
      #1;
      host_wr_en = 1'b1;
      host_page = pg;
      host_addr = ad;
      host_wr_data = dt;
      @(posedge mclk);
      rf = host_wr_refused;
      #1;
      host_wr_en = 1'b0;
      host_addr = ~ad;
      host_wr_data = ~dt;
   endtask

   task automatic rd(input logic [7:0] pg, input logic [5:0] ad, output logic [23:0] dt,
      output logic vl);
      @(posedge mclk);
      #1;
      host_rd_en = 1'b1;
      host_page = pg;
      host_addr = ad;
      @(posedge mclk);
      #1;
      host_rd_en = 1'b0;
      host_addr = ~ad;
      @(posedge mclk);
      dt = host_rd_data;
      vl = host_rd_valid;
   endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench of the register group through the host register port.
// Assumes mcsr_host_model for accesses and the bound port checker.
`timescale 1ns/100ps
module testbench;
   logic mclk, reset_n, host_wr_en, host_rd_en, host_rd_valid, host_wr_refused;
   logic [7:0] host_page, cmd_code;
   logic [5:0] host_addr;
   logic [23:0] host_wr_data, host_rd_data, m, pe;
   logic [25:0] pv;
   logic [3:0] osc, sel1, sel2, sel3;
   logic engine_lock, host_lock, interrupt_n, rf;
   int bad_count, samples_checked, cyc;
   int pos[22] = '{23, 23, 22, 21, 18, 16, 17, 6, 7, 8, 9, 14, 15, 12, 13, 10, 11, 5, 4, 3, 2, 0};
   logic [37:0] rt[8] = '{{8'h00, 6'h03, 24'h000000}, {8'h00, 6'h09, 24'h000000},
      {8'h00, 6'h17, 24'h800000}, {8'h00, 6'h18, 24'h801800}, {8'h00, 6'h22, 24'h000000},
      {8'h00, 6'h30, 24'h000000}, {8'h10, 6'h01, 24'h000000}, {8'h00, 6'h3f, 24'h000000}};

   mcsr_host_model u_mcsr_host_model (.mclk, .host_wr_en, .host_rd_en, .host_page, .host_addr,
      .host_wr_data, .host_rd_data, .host_rd_valid, .host_wr_refused);
   mcsr_regs u_mcsr_regs (.mclk, .reset_n, .host_wr_en, .host_rd_en, .host_page, .host_addr,
      .host_wr_data, .host_rd_data, .host_rd_valid, .host_wr_refused, .cmd_done(pv[0]),
      .cmd_valid(pv[25]), .cmd_code, .cmd_invalid(pv[19]), .low_rate_update(pv[1]),
      .sample_rate_update(pv[2]), .watchdog_overflow(pv[3]), .processing_overrun(pv[4]),
      .voltage_swell(pv[6:5]), .voltage_sag(pv[8:7]), .current_overcurrent(pv[10:9]),
      .power_range(pv[12:11]), .current_range(pv[14:13]), .voltage_range(pv[16:15]),
      .temperature_update(pv[17]), .frequency_update(pv[18]),
      .receive_checksum_error(pv[20]), .receive_timeout(pv[21]), .temp_modulator_osc(osc[3]),
      .voltage_modulator_osc(osc[2]), .current2_modulator_osc(osc[1]),
      .current1_modulator_osc(osc[0]), .output_word_rate_tick(pv[22]),
      .zero_cross_rise(pv[24]), .zero_cross_fall(pv[23]), .pulse_source_select1(sel1),
      .pulse_source_select2(sel2), .pulse_source_select3(sel3), .engine_lock, .host_lock,
      .interrupt_n);

   // ********************************************************
   // Helpers
   // ********************************************************
   task chk(input string nm, input logic [23:0] s, input logic [23:0] e);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask

   task wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task w(input logic [7:0] pg, input logic [5:0] ad, input logic [23:0] dt);
      u_mcsr_host_model.wr(pg, ad, dt, rf);
   endtask

   task r(input logic [7:0] pg, input logic [5:0] ad, input logic [23:0] e);
      logic [23:0] dt;
      logic vl;
      u_mcsr_host_model.rd(pg, ad, dt, vl);
      chk("read data", dt, e);
      chk("read valid", {23'h0, vl}, 24'h000001);
   endtask

   // Each pulse holds one design input high for exactly one cycle.
   task pulse(input int b, input int n);
      repeat (n) begin
         @(posedge mclk);
         #1;
         pv[b] = 1'b1;
         @(posedge mclk);
         #1;
         pv[b] = 1'b0;
      end
   endtask

   // ********************************************************
   // Clock, timeout and tests
   // ********************************************************
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         wrap_up;
      end
   end

   initial begin
      reset_n = 1'b0;
      pv = 26'h0;
      cmd_code = 8'h00;
      osc = 4'h0;
      repeat (10) @(posedge mclk);
      #1;
      reset_n = 1'b1;
      foreach (rt[i]) r(rt[i][37:30], rt[i][29:24], rt[i][23:0]);
      chk("interrupt idle", {23'h0, interrupt_n}, 24'h000001);
      $display("test reset done");
      for (int c = 0; c < 9; c++) begin
         pe = 24'(c * 257 + (8 - c) * 16);
         w(8'h00, 6'h09, 24'hfff000 | pe);
         r(8'h00, 6'h09, pe);
         chk("selector ports", {12'h000, sel3, sel2, sel1}, pe);
      end
      $display("test pulse selectors done");
      w(8'h00, 6'h03, 24'hffffff);
      r(8'h00, 6'h03, 24'he7fffd);
      chk("interrupt on reset event", {23'h0, interrupt_n}, 24'h000000);
      w(8'h00, 6'h17, 24'hffffff);
      r(8'h00, 6'h17, 24'h000000);
      for (int i = 0; i < 22; i++) begin
         m = 24'h000001 << pos[i];
         w(8'h00, 6'h03, m);
         pulse(i, 1);
         r(8'h00, 6'h17, m);
         chk("interrupt set", {23'h0, interrupt_n}, 24'h000000);
         w(8'h00, 6'h17, ~m);
         r(8'h00, 6'h17, m);
         w(8'h00, 6'h17, m);
         r(8'h00, 6'h17, 24'h000000);
         chk("interrupt cleared", {23'h0, interrupt_n}, 24'h000001);
      end
      $display("test events done");
      w(8'h00, 6'h22, 24'h000016);
      chk("host lock on", {23'h0, host_lock}, 24'h000001);
      w(8'h00, 6'h09, 24'h000777);
      chk("write refused", {23'h0, rf}, 24'h000001);
      r(8'h00, 6'h09, 24'h000808);
      w(8'h00, 6'h22, 24'h000005);
      chk("host lock kept", {23'h0, host_lock}, 24'h000001);
      w(8'h00, 6'h17, 24'hffffff);
      chk("status write allowed", {23'h0, rf}, 24'h000000);
      w(8'h00, 6'h22, 24'h001609);
      chk("locks after swap", {22'h0, engine_lock, host_lock}, 24'h000002);
      w(8'h00, 6'h22, 24'h000309);
      chk("engine lock kept", {23'h0, engine_lock}, 24'h000001);
      w(8'h00, 6'h22, 24'h000900);
      r(8'h00, 6'h22, 24'h000909);
      chk("engine lock off", {23'h0, engine_lock}, 24'h000000);
      $display("test locks done");
      w(8'h00, 6'h30, 24'h000016);
      pulse(22, 5);
      pulse(23, 1);
      pulse(24, 1);
      r(8'h00, 6'h30, 24'h850016);
      w(8'h00, 6'h30, 24'h000036);
      pulse(22, 3);
      pulse(24, 1);
      pulse(23, 1);
      r(8'h00, 6'h30, 24'h830036);
      w(8'h00, 6'h30, 24'h000035);
      pulse(22, 1);
      r(8'h00, 6'h30, 24'h830035);
      $display("test phase sequence done");
      #1;
      cmd_code = 8'ha5;
      pulse(25, 1);
      osc = 4'hf;
      r(8'h00, 6'h18, 24'h80a50f);
      r(8'h10, 6'h01, 24'h001147);
      $display("test condition and checksum done");
      w(8'h00, 6'h30, 24'h000016);
      pulse(22, 2);
      r(8'h00, 6'h30, 24'h020016);
      pulse(22, 126);
      pulse(24, 1);
      r(8'h00, 6'h30, 24'h7f0016);
      $display("test sample overflow done");
      wrap_up;
   end
endmodule
